/* File: hdl/gpp_pkg.sv */
// Package for the general-purpose I/O port: register offsets, reset values, widths.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package gpp_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_PIN_DIRECTION     = 8'h00;
  localparam logic [7:0] OFS_PIN_VALUE         = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_LATCH      = 8'h08;
  localparam logic [7:0] OFS_OPEN_DRAIN_ENABLE = 8'h0c;

  // ==========================================================================
  // Bus constants and reset values
  localparam int          ADDR_W     = 8;
  localparam int          PORT_W     = 16;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] RST_DIRECTION = 16'hffff;
  localparam logic [15:0] RST_LATCH     = 16'h0000;
  localparam logic [15:0] RST_OPEN_DRAIN = 16'h0000;

endpackage

/* File: hdl/gpp_port.sv */
// General-purpose I/O port with direction, pin value, output latch and open-drain control.
// Assumes an AXI4-Lite master on clk_sys and pad cells that resolve output enables.
`timescale 1ns/1ps

module gpp_port #(
  parameter logic [15:0] PIN_MASK    = 16'hffff, // Implemented pins
  parameter logic [15:0] ANALOG_MASK = 16'h0000  // Pins with analog function
) (
  // Clock and reset
  input  wire  logic        clk_sys,
  input  wire  logic        sys_rst,
  // AXI4-Lite write address
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Peripheral override per pin
  input  wire  logic [15:0] periph_enable,
  input  wire  logic [15:0] periph_out,
  input  wire  logic [15:0] periph_drive,
  // Pads
  input  wire  logic [15:0] pad_in,
  output logic [15:0]       pad_out,
  output logic [15:0]       pad_oe
);

  // ==========================================================================
  // Register map and bus timing
  // Four 16-bit registers, each in bits 15:0 of one word-aligned 32-bit slot:
  //   0x00 direction, 0x04 pin value, 0x08 output latch, 0x0c open-drain enable.
  // The upper half of every read is zero; the upper half of a write is ignored,
  // and only byte strobes 0 and 1 matter.
  // Direction resets to all ones, so no pin is driven until software clears a bit or an enabled peripheral drives it.
  // The pin-value slot reads synchronised pad levels but writes the output latch.
  // Software doing bit updates should use the latch slot: a read-modify-write
  // through the pin-value slot copies input levels into the latch, and a pin that
  // has not yet settled can clear a bit that was just set.
  // A write completes one cycle after both address and data are held and no earlier response waits; its
  // response then stands until the master takes it.
  // A read is answered on the edge after its address handshake and stands until
  // taken. Only one read is in flight at a time; a new write can be accepted while a write response waits.
  // Unmapped offsets answer with an error response and change nothing.
  // Bits of unimplemented pins read as zero and never drive their pads.

  // ==========================================================================
  // Registers and state
  logic [15:0] pin_direction;
  logic [15:0] output_latch;
  logic [15:0] open_drain_enable;
  logic [15:0] sync_a;
  logic [15:0] pin_value;
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        do_write;
  logic        wr_dir;
  logic        wr_lat;
  logic        wr_odc;
  logic        wr_hit;
  logic [15:0] rd_val;
  logic        rd_hit;
  logic [15:0] next_pad_out;
  logic [15:0] next_pad_oe;
  logic [15:0] own_data;
  logic [15:0] own_drive;
  logic [15:0] od_mask;

  // ==========================================================================
  // Pin synchroniser
  // First stage: may go metastable, so nothing but the second stage reads it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= 16'h0000;
    end else begin
      sync_a <= pad_in;
    end
  end

  // Second stage: the settled pin levels seen by pin-value reads
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_value <= 16'h0000;
    end else begin
      pin_value <= sync_a;
    end
  end

  // ==========================================================================
  // Write channel: address and data accepted in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Address capture
  // Ready is offered every other idle cycle and drops after a handshake, so a
  // held address is never overwritten before its write completes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  // Data capture
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write decode
  always_comb begin
    wr_hit = 1'b0;
    unique case (aw_addr)
      gpp_pkg::OFS_PIN_DIRECTION, gpp_pkg::OFS_PIN_VALUE,
      gpp_pkg::OFS_OUTPUT_LATCH, gpp_pkg::OFS_OPEN_DRAIN_ENABLE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Byte-lane merge helper for 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [15:0] r;
    r = cur;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // Per-register write strobes, high only in the cycle a write completes
  assign wr_dir = do_write && (aw_addr == gpp_pkg::OFS_PIN_DIRECTION);
  assign wr_lat = do_write && (aw_addr == gpp_pkg::OFS_PIN_VALUE ||
                               aw_addr == gpp_pkg::OFS_OUTPUT_LATCH);
  assign wr_odc = do_write && (aw_addr == gpp_pkg::OFS_OPEN_DRAIN_ENABLE);

  // Direction register, reset to all inputs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_direction <= gpp_pkg::RST_DIRECTION;
    end else if (wr_dir) begin
      pin_direction <= merge(pin_direction, w_data, w_strb) & PIN_MASK;
    end
  end

  // Output latch: written through pin value or latch offset alike
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      output_latch <= gpp_pkg::RST_LATCH;
    end else if (wr_lat) begin
      output_latch <= merge(output_latch, w_data, w_strb) & PIN_MASK;
    end
  end

  // Open-drain enables, held at zero on analog-capable pins
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      open_drain_enable <= gpp_pkg::RST_OPEN_DRAIN;
    end else if (wr_odc) begin
      open_drain_enable <= merge(open_drain_enable, w_data, w_strb)
                           & PIN_MASK & ~ANALOG_MASK;
    end
  end

  // Write response
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpp_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? gpp_pkg::RESP_OKAY : gpp_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Read channel
  // The mux follows the live address so the word is caught at the handshake;
  // direction resets to all ones, so unimplemented bits are masked here
  always_comb begin
    rd_val = 16'h0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      gpp_pkg::OFS_PIN_DIRECTION:     rd_val = pin_direction & PIN_MASK;
      gpp_pkg::OFS_PIN_VALUE:         rd_val = pin_value & PIN_MASK;
      gpp_pkg::OFS_OUTPUT_LATCH:      rd_val = output_latch;
      gpp_pkg::OFS_OPEN_DRAIN_ENABLE: rd_val = open_drain_enable;
      default:                        rd_hit = 1'b0;
    endcase
  end

  // Read address ready: offered only while no read data waits; it drops
  // after a handshake so the captured word cannot be replaced before use
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
    end
  end

  // Read data return: captured at the handshake, held until accepted
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= gpp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_hit ? gpp_pkg::RESP_OKAY : gpp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Pin output multiplexer
  // Peripheral wins data and driver; the port's open-drain enable still applies to that pin
  assign own_data  = (periph_enable & periph_out) | (~periph_enable & output_latch);
  assign own_drive = (periph_enable & periph_drive)
                     | (~periph_enable & ~pin_direction);
  assign od_mask   = open_drain_enable;

  // Open-drain pins drive only a low level: a high bit turns the driver off
  // and leaves the line to its external pull-up; data on such a pin is held
  // low so a stray enable can never push a high level out
  always_comb begin
    next_pad_out = own_data & ~od_mask & PIN_MASK;
    next_pad_oe  = own_drive & ~(od_mask & own_data) & PIN_MASK;
  end

  // Pad data registered: a write shows on the pins one cycle later
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pad_out <= 16'h0000;
    end else begin
      pad_out <= next_pad_out;
    end
  end

  // Pad enables registered alongside; reset leaves every driver off
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pad_oe <= 16'h0000;
    end else begin
      pad_oe <= next_pad_oe;
    end
  end

endmodule

/* File: tb/gpp_pins.sv */
// External devices on the pins; every line has a pull-up.
// Assumes the bench drives ext_val and ext_oe.
`timescale 1ns/1ps
module gpp_pins (
  // Port side
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  // Device side
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_oe,
  output logic      [15:0] pad_in
);
  // ==========
  // Port wins, else device, else released line pulls up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ((ext_oe & ext_val) | ~ext_oe));
endmodule

/* File: tb/gpp_port_monitor.sv */
// Checker of bus answers and pad enables of the port.
// Assumes binding into gpp_port; sees only its ports.
`timescale 1ns/1ps
module gpp_port_chk #(
  parameter logic [15:0] PIN_MASK = 16'hffff
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Bus handshakes and read data
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Peripheral and pads
  input wire logic [15:0] periph_enable,
  input wire logic [15:0] periph_drive,
  input wire logic [15:0] pad_oe
);
  // ==========
  // Set once any write has been answered since reset
  logic wrote;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) wrote <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready) wrote <= 1'b1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_RST_IN: assert property (disable iff (1'b0) sys_rst |-> pad_oe == 16'h0000)
    else $error("pad driven during reset");
  AST_ALL_IN: assert property (!wrote && $past(periph_enable) == 16'h0000 |-> pad_oe == 16'h0000)
    else $error("pad driven before any write");
  AST_MASK: assert property ((pad_oe & ~PIN_MASK) == 16'h0000)
    else $error("unimplemented pin driven");
  AST_PERIPH_OFF: assert property (($past(periph_enable) & ~$past(periph_drive) & pad_oe) == 16'h0000)
    else $error("peripheral driver off but pad driven");
  AST_WR_ANS: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  AST_RD_ANS: assert property (rd_taken |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read not answered next cycle");
  AST_RD_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  AST_RD_UP: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
endmodule
bind gpp_port gpp_port_chk #(
  .PIN_MASK(PIN_MASK)
) gpp_port_chk_i (
  .clk_sys      (clk_sys),
  .sys_rst      (sys_rst),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid (s_axi_wvalid),
  .s_axi_wready (s_axi_wready),
  .s_axi_bvalid (s_axi_bvalid),
  .s_axi_bready (s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid (s_axi_rvalid),
  .s_axi_rready (s_axi_rready),
  .s_axi_rdata  (s_axi_rdata),
  .periph_enable(periph_enable),
  .periph_drive (periph_drive),
  .pad_oe       (pad_oe)
);

/* File: tb/testbench.sv */
// Bench: bus tasks and register and pad scenarios.
// Assumes gpp_port, gpp_pins and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
  // ==========
  // Signals
  logic clk_sys = 1'b0, sys_rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic awr, wr_r, bv, arr, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd_d;
  logic [1:0] bresp, rresp, r;
  logic [15:0] pen = 16'h0, pout = 16'h0, pdrv = 16'h0, ev = 16'h0, eoe = 16'h0;
  logic [15:0] pad_in, pad_out, pad_oe, d;
  int n_fail = 0, checks_done = 0, cyc = 0;
  gpp_port #(.PIN_MASK(16'h7fff), .ANALOG_MASK(16'h0001)) gpp_port_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .periph_enable(pen),
    .periph_out(pout), .periph_drive(pdrv), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe));
  gpp_pins gpp_pins_i (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ev), .ext_oe(eoe),
    .pad_in(pad_in));
  // Clock and cycle limit
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  // Bus write: offer both channels, wait for the answer
  task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] rs);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awa <= a;
    wd <= {16'h0000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk_sys);
      if (!ad && awr === 1'b1) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wr_r === 1'b1) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (bv !== 1'b1);
    rs = bresp;
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic [1:0] rs);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk_sys); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk_sys); while (rv !== 1'b1);
    v = rd_d[15:0];
    rs = rresp;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_r(input string nm, input logic [1:0] e, input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic results;
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    wt(6);
    sys_rst <= 1'b0;
    wt(1);
    rd(gpp_pkg::OFS_PIN_DIRECTION, d, r);
    chk("dir", 16'h7fff, d);
    rd(gpp_pkg::OFS_OPEN_DRAIN_ENABLE, d, r);
    chk("odc", 16'h0000, d);
    ev <= 16'ha5c3;
    eoe <= 16'hffff;
    wt(4);
    rd(gpp_pkg::OFS_PIN_VALUE, d, r);
    chk("pin", 16'h25c3, d);
    wr(gpp_pkg::OFS_PIN_VALUE, 16'h1234, r);
    rd(gpp_pkg::OFS_OUTPUT_LATCH, d, r);
    chk("lat", 16'h1234, d);
    wr(gpp_pkg::OFS_OUTPUT_LATCH, 16'hffff, r);
    chk_r("bresp", gpp_pkg::RESP_OKAY, r);
    rd(gpp_pkg::OFS_OUTPUT_LATCH, d, r);
    chk("lat", 16'h7fff, d);
    wr(gpp_pkg::OFS_PIN_DIRECTION, 16'h0000, r);
    eoe <= 16'h0000;
    wt(4);
    chk("oe", 16'h7fff, pad_oe);
    rd(gpp_pkg::OFS_PIN_VALUE, d, r);
    chk("pin", 16'h7fff, d);
    // Latch used for bit updates while outputs drive the pins
    wr(gpp_pkg::OFS_OUTPUT_LATCH, 16'h02f1, r);
    wr(gpp_pkg::OFS_OPEN_DRAIN_ENABLE, 16'h01ff, r);
    rd(gpp_pkg::OFS_OPEN_DRAIN_ENABLE, d, r);
    chk("odc", 16'h01fe, d);
    wt(4);
    chk("oe", 16'h7f0f, pad_oe);
    chk("out", 16'h0201, pad_out);
    rd(gpp_pkg::OFS_PIN_VALUE, d, r);
    chk("pin", 16'h02f1, d);
    pen <= 16'h0300;
    pout <= 16'h0100;
    pdrv <= 16'h0100;
    wt(2);
    chk("oe", 16'h7c0f, pad_oe);
    chk("out", 16'h0001, pad_out);
    wr(8'h10, 16'hffff, r);
    chk_r("bresp", gpp_pkg::RESP_SLVERR, r);
    rd(8'h10, d, r);
    chk_r("rresp", gpp_pkg::RESP_SLVERR, r);
    chk("unm", 16'h0000, d);
    results();
  end
endmodule
